// ### verilog/iic_ctrl_status.sv
// iic protocol control, slave address match and sticky status flags
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// [R1] first address byte compared with own address bits 15..9
// [R2] ten-bit prefix in bits 15..11 adds second byte compare with bits 7..0
// [R3] timing bit picks 10 quanta (standard) or 25 quanta (fast) per symbol
// [R4] slave ack suppress clears itself on start or repeated start unless a control high write lands in the same cycle
// [R5] suppress set before an ack bit makes that ack passive high
// [R6] four-bit hold delay postpones sda changes after scl falls
// [R7] master clock output runs only when enabled, else held at 0
// [R8] reserved control and status bits read 0; software writes 0
// [R9] status flags are never cleared by hardware
// [R10] flag 0 set when addressed and selected as slave
// [R11] flag 1 set on wrong transmit format code; fault enable interrupts
// [R12] flag 2 set on start condition; interrupt enable is control bit 18
// [R13] flag 3 set on repeated start; restart enable interrupts
// [R14] flag 4 set on stop condition; interrupt enable is control bit 20
// [R15] flag 5 set on master non-acknowledge only; enable bit 21
// [R16] flag 6 set on arbitration loss; enable bit 22
// [R17] flag 7 set on slave read request; enable bit 23
// [R18] flag 8 set on frame or format code error; enable bit 24
// [R19] interrupt pulses when an enabled flag newly sets
module iic_ctrl_status
    import iic_status_pkg::*;
#(
    parameter int MCLK_HALF = MCLK_DIV
) (
    input  wire logic              sys_clk_in,
    input  wire logic              rst_n_in,
    input  wire logic              clk_en_in,
    input  wire reg_req_s          reg_req_in,
    output logic [DATA_W-1:0]      reg_rdata_out,
    input  wire logic              scl_in,
    input  wire logic              sda_in,
    output logic                   sda_out,
    output logic                   sda_oe_out,
    input  wire master_evt_s       master_evt_in,
    output logic [4:0]             quanta_per_symbol_out,
    output logic [3:0]             hold_delay_out,
    output logic                   mclk_out,
    output logic                   proto_irq_out,
    output logic                   slave_selected_out
);

    // ************************************************************
    // registers and decode
    // ************************************************************
    logic [31:0]      ctrl;
    logic [NFLAG-1:0] status;
    logic [NFLAG-1:0] next_set;
    logic [NFLAG-1:0] irq_en;
    logic             wr_lo;
    logic             wr_hi;
    logic             wr_st;

    assign wr_lo = reg_req_in.wr && reg_req_in.addr == CTRL_LO_ADDR;
    assign wr_hi = reg_req_in.wr && reg_req_in.addr == CTRL_HI_ADDR;
    assign wr_st = reg_req_in.wr && reg_req_in.addr == STATUS_ADDR;

    // ************************************************************
    // pin synchronisers and bus conditions
    // ************************************************************
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic       scl_prev;
    logic       sda_prev;
    logic       scl_rise;
    logic       scl_fall;
    logic       start_det;
    logic       stop_det;
    logic       bus_busy;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else if (clk_en_in) begin
            scl_sync <= {scl_sync[0], scl_in};
            sda_sync <= {sda_sync[0], sda_in};
            scl_prev <= scl_sync[1];
            sda_prev <= sda_sync[1];
        end
    end

    assign scl_rise  = scl_sync[1] && !scl_prev;
    assign scl_fall  = !scl_sync[1] && scl_prev;
    assign start_det = scl_sync[1] && scl_prev && sda_prev && !sda_sync[1];
    assign stop_det  = scl_sync[1] && scl_prev && !sda_prev && sda_sync[1];

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            bus_busy <= 1'b0;
        end else if (clk_en_in) begin
            if (start_det) begin
                bus_busy <= 1'b1;
            end else if (stop_det) begin
                bus_busy <= 1'b0;
            end
        end
    end

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            ctrl <= CTRL_RESET;
        end else if (clk_en_in) begin
            if (wr_lo) begin
                ctrl[15:0] <= reg_req_in.wdata[15:0];
            end
            if (wr_hi) begin
                ctrl[31:16] <= reg_req_in.wdata[15:0] & CTRL_WMASK[31:16]; // R8
            end else if (start_det) begin
                // a control high write in the same cycle wins over the auto clear
                ctrl[SACK_BIT] <= 1'b0; // R4
            end
        end
    end

    assign quanta_per_symbol_out = ctrl[SYMBOL_TIMING_SELECT_BIT] ? TQ_FAST : TQ_STANDARD; // R3
    assign hold_delay_out        = ctrl[HOLD_DELAY_COMP_HI:HOLD_DELAY_COMP_LO];

    // ************************************************************
    // slave address recognition
    // ************************************************************
    slave_state_e state;
    logic [3:0]   bit_cnt;
    logic [7:0]   shift;
    logic         selected;
    logic         read_mode;
    logic         sel_evt;
    logic         srr_evt;
    logic         want_oe;

    function automatic logic ten_bit_mode(input logic [15:0] own);
        return own[OWN_SLAVE_ADDRESS_HI -: 5] == TEN_BIT_PFX;
    endfunction : ten_bit_mode

    function automatic logic hdr_match(input logic [15:0] own, input logic [7:0] b);
        if (ten_bit_mode(own)) begin
            return b[7:3] == TEN_BIT_PFX && b[2:1] == own[10:9]; // R2
        end
        return b[7:1] == own[OWN_SLAVE_ADDRESS_HI:9]; // R1
    endfunction : hdr_match

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state     <= SL_IDLE;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            selected  <= 1'b0;
            read_mode <= 1'b0;
            sel_evt   <= 1'b0;
            srr_evt   <= 1'b0;
            want_oe   <= 1'b0;
        end else if (clk_en_in) begin
            sel_evt <= 1'b0;
            srr_evt <= 1'b0;
            if (start_det) begin
                state   <= SL_ADDR1;
                bit_cnt <= 4'h0;
                want_oe <= 1'b0;
            end else if (stop_det) begin
                state    <= SL_IDLE;
                selected <= 1'b0;
                want_oe  <= 1'b0;
            end else if (state != SL_IDLE && scl_rise && bit_cnt < BIT_DONE) begin
                if (bit_cnt < BIT_ACK) begin
                    shift <= {shift[6:0], sda_sync[1]};
                end
                bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == BIT_DONE) begin
                bit_cnt <= 4'h0;
                want_oe <= 1'b0;
            end else if (scl_fall && bit_cnt == BIT_ACK) begin
                unique case (state)
                    SL_ADDR1: begin
                        if (!hdr_match(ctrl[15:0], shift)) begin
                            state    <= SL_SKIP;
                            selected <= 1'b0;
                        end else if (ten_bit_mode(ctrl[15:0]) && !shift[0]) begin
                            state   <= SL_ADDR2;
                            want_oe <= !ctrl[SACK_BIT]; // R5
                        end else if (ten_bit_mode(ctrl[15:0]) && !selected) begin
                            // ten-bit read header is only valid after a full match
                            state <= SL_SKIP;
                        end else begin
                            state     <= SL_DATA;
                            selected  <= 1'b1;
                            read_mode <= shift[0];
                            sel_evt   <= 1'b1; // R10
                            srr_evt   <= shift[0]; // R17
                            want_oe   <= !ctrl[SACK_BIT]; // R5
                        end
                    end
                    SL_ADDR2: begin
                        if (shift == ctrl[7:0]) begin
                            state     <= SL_DATA;
                            selected  <= 1'b1;
                            read_mode <= 1'b0;
                            sel_evt   <= 1'b1; // R10
                            want_oe   <= !ctrl[SACK_BIT]; // R5
                        end else begin
                            state    <= SL_SKIP;
                            selected <= 1'b0;
                        end
                    end
                    SL_DATA: begin
                        want_oe <= !read_mode && !ctrl[SACK_BIT]; // R5
                    end
                    SL_SKIP: begin
                        want_oe <= 1'b0;
                    end
                    default: begin
                        state <= SL_IDLE;
                    end
                endcase
            end
        end
    end

    assign slave_selected_out = selected;

    // ************************************************************
    // sda drive with hold delay compensation
    // ************************************************************
    logic [3:0] hold_cnt;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            hold_cnt   <= 4'h0;
            sda_oe_out <= 1'b0;
        end else if (clk_en_in) begin
            // sda only moves once the programmed delay after scl low has run out
            if (scl_fall) begin
                hold_cnt <= ctrl[HOLD_DELAY_COMP_HI:HOLD_DELAY_COMP_LO]; // R6
            end else if (hold_cnt != 4'h0) begin
                hold_cnt <= hold_cnt - 4'h1; // R6
            end else begin
                sda_oe_out <= want_oe;
            end
        end
    end

    assign sda_out = 1'b0;

    // ************************************************************
    // master clock output
    // ************************************************************
    logic [7:0] mclk_cnt;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mclk_cnt <= 8'h00;
            mclk_out <= 1'b0;
        end else if (clk_en_in) begin
            if (!ctrl[MCLK_BIT]) begin
                mclk_cnt <= 8'h00;
                mclk_out <= 1'b0; // R7
            end else if (mclk_cnt == 8'(MCLK_HALF - 1)) begin
                mclk_cnt <= 8'h00;
                mclk_out <= !mclk_out;
            end else begin
                mclk_cnt <= mclk_cnt + 8'h01;
            end
        end
    end

    // ************************************************************
    // status flags and protocol interrupt
    // ************************************************************
    always_comb begin
        next_set              = '0;
        next_set[ST_ADDRESSED_AS_SLAVE]    = sel_evt; // R10
        next_set[ST_BADCODE]  = master_evt_in.wrong_code; // R11
        next_set[ST_START]    = start_det && !bus_busy; // R12
        next_set[ST_RESTART]  = start_det && bus_busy; // R13
        next_set[ST_STOP]     = stop_det; // R14
        next_set[ST_NO_ACK_FLAG]     = master_evt_in.master_mode
                                && master_evt_in.master_no_ack_flag; // R15
        next_set[ST_ARL]      = master_evt_in.arb_lost; // R16
        next_set[ST_SRR]      = srr_evt; // R17
        next_set[ST_ERR]      = master_evt_in.frame_err
                                || master_evt_in.wrong_code; // R18
    end

    assign irq_en = {ctrl[FAULT_IEN], ctrl[SRR_IEN], ctrl[ARL_IEN], ctrl[NO_ACK_FLAG_IEN],
                     ctrl[STOP_IEN], ctrl[RESTART_IEN], ctrl[START_IEN],
                     ctrl[FAULT_IEN], 1'b0};

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            status <= STATUS_RESET;
        end else if (clk_en_in) begin
            // write one to clear; a new event in the same cycle wins
            status <= (status & ~(wr_st ? reg_req_in.wdata[NFLAG-1:0] : '0))
                      | next_set; // R9
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            proto_irq_out <= 1'b0;
        end else if (clk_en_in) begin
            proto_irq_out <= |(next_set & ~status & irq_en); // R19
        end
    end

    // ************************************************************
    // register read port
    // ************************************************************
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            reg_rdata_out <= '0;
        end else if (clk_en_in) begin
            reg_rdata_out <= '0;
            if (reg_req_in.rd) begin
                unique case (reg_req_in.addr)
                    CTRL_LO_ADDR: reg_rdata_out[15:0]      <= ctrl[15:0];
                    CTRL_HI_ADDR: reg_rdata_out[15:0]      <= ctrl[31:16];
                    STATUS_ADDR:  reg_rdata_out[NFLAG-1:0] <= status; // R8
                    default:      reg_rdata_out            <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in || !clk_en_in);

    sequence start_seq;
        start_det && !wr_hi;
    endsequence

    sequence ack_slot_seq;
        scl_fall && bit_cnt == BIT_ACK && state == SL_DATA && ctrl[SACK_BIT];
    endsequence

    sticky_flags_a: assert property ((status != '0 && !wr_st) |=> // R9
        (status & $past(status)) == $past(status))
        else $error("status flag dropped without software clear");
    ack_suppress_clr_a: assert property (start_seq |=> !ctrl[SACK_BIT]) // R4
        else $error("ack suppress not cleared on start");
    ack_passive_a: assert property (ack_slot_seq |=> !want_oe) // R5
        else $error("ack driven low while suppressed");
    start_flag_a: assert property (start_det && !bus_busy |=> status[ST_START]) // R12
        else $error("start flag not set");
    stop_flag_a: assert property (stop_det |=> status[ST_STOP] ##1 !bus_busy) // R14
        else $error("stop flag or bus idle missing");
    timing_sel_a: assert property ($changed(quanta_per_symbol_out) // R3
        |-> $past(wr_hi))
        else $error("symbol timing changed without control write");
    mclk_gate_a: assert property (!ctrl[MCLK_BIT] |=> !mclk_out) // R7
        else $error("master clock runs while disabled");
    no_ack_flag_master_a: assert property ($rose(status[ST_NO_ACK_FLAG]) |-> // R15
        $past(master_evt_in.master_mode))
        else $error("no_ack_flag flag set in slave mode");
    // held against the flag register itself, so a missed flag set shows up even where
    // the pulse logic agrees with itself; the enable map is the same irq_en it uses
    irq_cause_a: assert property (proto_irq_out |-> // R19
        (status & ~$past(status) & $past(irq_en)) != '0)
        else $error("interrupt without enabled new flag");
    reserved_rd_a: assert property (reg_req_in.rd && reg_req_in.addr == STATUS_ADDR // R8
        |=> reg_rdata_out[DATA_W-1:NFLAG] == '0)
        else $error("reserved status bits not zero");

endmodule : iic_ctrl_status

// ### verilog/iic_status_pkg.sv
// constants, field layout and carriers for the iic protocol control/status block
package iic_status_pkg;

    // ************************************************************
    // register map (byte offsets on the plain register port)
    // ************************************************************
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 32;
    localparam logic [7:0]  CTRL_LO_ADDR  = 8'h00;
    localparam logic [7:0]  CTRL_HI_ADDR  = 8'h04;
    localparam logic [7:0]  STATUS_ADDR   = 8'h08;

    // ************************************************************
    // control word fields (bit positions in the 32-bit control word)
    // ************************************************************
    localparam int          OWN_SLAVE_ADDRESS_HI       = 15;
    localparam int          ACK00_BIT     = 16;
    localparam int          SYMBOL_TIMING_SELECT_BIT      = 17;
    localparam int          START_IEN     = 18;
    localparam int          RESTART_IEN   = 19;
    localparam int          STOP_IEN      = 20;
    localparam int          NO_ACK_FLAG_IEN      = 21;
    localparam int          ARL_IEN       = 22;
    localparam int          SRR_IEN       = 23;
    localparam int          FAULT_IEN     = 24;
    localparam int          SACK_BIT      = 25;
    localparam int          HOLD_DELAY_COMP_LO       = 26;
    localparam int          HOLD_DELAY_COMP_HI       = 29;
    localparam int          MCLK_BIT      = 31;
    localparam logic [31:0] CTRL_WMASK    = 32'hBFFF_FFFF;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;

    // ************************************************************
    // status flags
    // ************************************************************
    localparam int          NFLAG         = 9;
    localparam int          ST_ADDRESSED_AS_SLAVE      = 0;
    localparam int          ST_BADCODE    = 1;
    localparam int          ST_START      = 2;
    localparam int          ST_RESTART    = 3;
    localparam int          ST_STOP       = 4;
    localparam int          ST_NO_ACK_FLAG       = 5;
    localparam int          ST_ARL        = 6;
    localparam int          ST_SRR        = 7;
    localparam int          ST_ERR        = 8;
    localparam logic [8:0]  STATUS_RESET  = 9'h000;

    // ************************************************************
    // symbol timing and address matching
    // ************************************************************
    localparam logic [4:0]  TQ_STANDARD   = 5'h0A;
    localparam logic [4:0]  TQ_FAST       = 5'h19;
    localparam logic [4:0]  TEN_BIT_PFX   = 5'h1E;
    localparam logic [3:0]  BIT_ACK       = 4'h8;
    localparam logic [3:0]  BIT_DONE      = 4'h9;
    localparam int          MCLK_DIV      = 4;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_s;

    typedef struct packed {
        logic wrong_code;
        logic frame_err;
        logic master_no_ack_flag;
        logic arb_lost;
        logic master_mode;
    } master_evt_s;

    typedef enum logic [2:0] {
        SL_IDLE  = 3'b000,
        SL_ADDR1 = 3'b001,
        SL_ADDR2 = 3'b011,
        SL_DATA  = 3'b010,
        SL_SKIP  = 3'b110
    } slave_state_e;

endpackage : iic_status_pkg

// ### sim/iic_bus_model.sv
// behavioural iic bus master that frames transfers on the link clock
`timescale 1ns/10ps
module iic_bus_model (
    output logic      scl_out,
    output logic      sda_drv_out,
    input  wire logic sda_in
);
    // ************************************************************
    // bus framing, 48 ns link clock
    // ************************************************************
    localparam time HALF = 24;

    // released lines float high on the pull-ups; clock stands still between frames
    initial begin
        scl_out = 1'b1;
        sda_drv_out = 1'b1;
    end

    task automatic start_cond();
        sda_drv_out = 1'b0;
        #HALF;
        scl_out = 1'b0;
        #HALF;
    endtask : start_cond

    // entered with scl low after a completed byte
    task automatic restart_cond();
        #(HALF / 2);
        sda_drv_out = 1'b1;
        #(HALF / 2);
        scl_out = 1'b1;
        #HALF;
        start_cond();
    endtask : restart_cond

    task automatic stop_cond();
        #(HALF / 2);
        sda_drv_out = 1'b0;
        #(HALF / 2);
        scl_out = 1'b1;
        #HALF;
        sda_drv_out = 1'b1;
        #HALF;
    endtask : stop_cond

    // msb first, then the ninth bit is left to the addressed slave; sda moves only half a
    // phase after scl falls, since a change on the same instant could pass for a start
    task automatic send_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            #(HALF / 2);
            sda_drv_out = b[i];
            #(HALF / 2);
            scl_out = 1'b1;
            #HALF;
            scl_out = 1'b0;
        end
        #(HALF / 2);
        sda_drv_out = 1'b1;
        #(HALF / 2);
        scl_out = 1'b1;
        #(HALF / 2);
        ack = sda_in;
        #(HALF / 2);
        scl_out = 1'b0;
    endtask : send_byte
endmodule : iic_bus_model

// ### sim/tb_iic_ctrl_status.sv
// self-checking bench for the iic protocol control/status block
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin failures++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module tb_iic_ctrl_status
    import iic_status_pkg::*;
;
    logic              sys_clk_in;
    logic              rst_n_in;
    reg_req_s          req;
    master_evt_s       evt;
    logic [DATA_W-1:0] rdata;
    logic              sda_oe;
    logic              mclk;
    logic              irq;
    logic              sel;
    logic [4:0]        tq;
    logic [3:0]        hd;
    logic              scl_w;
    logic              sda_drv;
    logic              sda_o;
    wire               sda_w;
    int                failures;
    int                total_checks;
    int                irq_cnt = 0;
    logic [31:0]       seed;
    localparam master_evt_s EV[5] = '{5'h10, 5'h08, 5'h05, 5'h02, 5'h04};
    localparam logic [15:0] FL[5] = '{16'h0102, 16'h0100, 16'h0020, 16'h0040, 16'h0000};

    // open-drain wire: pull-up unless anyone pulls low
    assign sda_w = sda_drv & (~sda_oe | sda_o);

    iic_ctrl_status #(.MCLK_HALF(2)) iic_ctrl_status_inst (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .reg_req_in(req), .reg_rdata_out(rdata), .scl_in(scl_w), .sda_in(sda_w),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .master_evt_in(evt),
        .quanta_per_symbol_out(tq), .hold_delay_out(hd), .mclk_out(mclk),
        .proto_irq_out(irq), .slave_selected_out(sel));

    iic_bus_model iic_bus_model_inst (.scl_out(scl_w), .sda_drv_out(sda_drv), .sda_in(sda_w));

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic [15:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[15:0];
    endfunction : xs

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: {16'h0, d}, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        req.wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge sys_clk_in);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        req.rd <= 1'b0;
        #1 `CHK(rdata, {16'h0, e})
    endtask : rd

    task automatic pulse(input master_evt_s e);
        @(posedge sys_clk_in);
        evt <= e;
        @(posedge sys_clk_in);
        evt <= '0;
        repeat (2) @(posedge sys_clk_in);
    endtask : pulse

    task automatic end_of_test();
        if (failures == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test

    initial begin
        sys_clk_in = 1'b0;
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    always @(posedge sys_clk_in) if (irq === 1'b1) irq_cnt <= irq_cnt + 1;

    // whole run is well under a fifth of this
    initial begin
        #400000;
        failures++;
        end_of_test();
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [15:0] r;
        logic [15:0] own;
        logic [6:0]  a;
        logic        ack;
        int          n;
        failures = 0; total_checks = 0; seed = 32'h61;
        rst_n_in = 1'b0; req = '0; evt = '0;
        repeat (16) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        rd(STATUS_ADDR, 16'h0000);
        rd(CTRL_HI_ADDR, 16'h0000);
        for (int i = 0; i < 5; i++) begin
            r = (i == 0) ? 16'hFFFF : xs();
            wr(CTRL_HI_ADDR, r);
            wr(CTRL_LO_ADDR, ~r);
            rd(CTRL_HI_ADDR, r & 16'hBFFF);
            rd(CTRL_LO_ADDR, ~r);
            `CHK(tq, r[1] ? 5'h19 : 5'h0A)
            `CHK(hd, r[13:10])
        end
        wr(8'h0C, xs());
        rd(8'h0C, 16'h0000);
        rd(CTRL_LO_ADDR, ~r);
        wr(CTRL_HI_ADDR, 16'h0000);
        // the gate acts one edge after the control write lands
        @(posedge sys_clk_in);
        n = 0;
        repeat (40) @(negedge sys_clk_in) n += mclk;
        `CHK(n, 0)
        wr(CTRL_HI_ADDR, 16'h8000);
        n = 0;
        repeat (40) @(negedge sys_clk_in) n += mclk;
        `CHK(n, 20)
        wr(STATUS_ADDR, 16'h01FF);
        for (int p = 0; p < 2; p++) begin
            wr(CTRL_HI_ADDR, p ? 16'h0000 : 16'h01FC);
            for (int k = 0; k < 5; k++) begin
                n = irq_cnt;
                pulse(EV[k]);
                rd(STATUS_ADDR, FL[k]);
                rd(STATUS_ADDR, FL[k]);
                `CHK(irq_cnt - n, (p == 0 && FL[k] != 0) ? 1 : 0)
                wr(STATUS_ADDR, 16'h01FF);
            end
        end
        a = 7'(xs());
        if (a[6:2] == 5'h1E) a[6] = 1'b0;
        wr(CTRL_LO_ADDR, {a, 9'h000});
        wr(CTRL_HI_ADDR, 16'h009C);
        n = irq_cnt;
        iic_bus_model_inst.start_cond();
        rd(STATUS_ADDR, 16'h0004);
        `CHK(irq_cnt - n, 1)
        iic_bus_model_inst.send_byte({a, 1'b0}, ack);
        `CHK(ack, 1'b0)
        `CHK(sel, 1'b1)
        rd(STATUS_ADDR, 16'h0005);
        iic_bus_model_inst.send_byte(8'(xs()), ack);
        `CHK(ack, 1'b0)
        wr(CTRL_HI_ADDR, 16'h029C);
        iic_bus_model_inst.send_byte(8'(xs()), ack);
        `CHK(ack, 1'b1)
        iic_bus_model_inst.restart_cond();
        rd(CTRL_HI_ADDR, 16'h009C);
        iic_bus_model_inst.send_byte({a, 1'b1}, ack);
        `CHK(ack, 1'b0)
        rd(STATUS_ADDR, 16'h008D);
        iic_bus_model_inst.stop_cond();
        rd(STATUS_ADDR, 16'h009D);
        wr(STATUS_ADDR, 16'h01FF);
        iic_bus_model_inst.start_cond();
        iic_bus_model_inst.send_byte({a ^ 7'h01, 1'b0}, ack);
        `CHK(ack, 1'b1)
        iic_bus_model_inst.stop_cond();
        own = xs();
        own[15:11] = 5'h1E;
        wr(CTRL_LO_ADDR, own);
        for (int p = 0; p < 2; p++) begin
            wr(STATUS_ADDR, 16'h01FF);
            iic_bus_model_inst.start_cond();
            iic_bus_model_inst.send_byte({own[15:9], 1'b0}, ack);
            `CHK(ack, 1'b0)
            iic_bus_model_inst.send_byte(own[7:0] ^ 8'(p), ack);
            `CHK(ack, 1'(p))
            iic_bus_model_inst.stop_cond();
            rd(STATUS_ADDR, p ? 16'h0014 : 16'h0015);
        end
        end_of_test();
    end
endmodule : tb_iic_ctrl_status
